// ### design/sdram_cmd_cfg.svh
/*
 Constants for the SDRAM command decoder and its controller end.
 Assumes inclusion by bare name from the package; both ends see it through compile order.
*/
// How it works
// - write-burst-mode bit set makes writes single
// - strobes decode eight commands while selected
// - chip select high executes nothing new
// - nop registers nothing, bursts continue
// - controller loads mode only when idle
// - activate opens row until bank precharged
// - column and auto-precharge flag from address, bank from bank select
// - read mask acts two clocks later
// - write mask acts in same cycle
// - auto precharge closes row at burst end
// - precharge one bank, or all with flag
// - precharged bank idle after precharge period
// - auto precharge per command, never full page
// - controller waits precharge period after auto precharge
// - burst terminate cuts latest burst short
// - clock gate high refresh auto, low self
// - controller refuses refresh until all banks precharged
// - refresh uses internal row counter
// - controller flags refresh due 8192 times per 64ms
// - read latency two or three clocks
// - burst order sequential or interleaved
`ifndef SDRAM_CMD_CFG_SVH
`define SDRAM_CMD_CFG_SVH
`define ROW_W 13
`define COL_W 10
`define BANKS 4
`define PRE_FLAG_BIT 10
`define MODE_BL_LSB 0
`define MODE_BT_BIT 3
`define MODE_CL_LSB 4
`define MODE_WB_BIT 9
`define MODE_RESET 12'h020
`define CLK_NS 40
`define TRP_NS 20
`define MODE_LOAD_DELAY_CYC 2
`define TRP_CYC ((`TRP_NS + `CLK_NS - 1) / `CLK_NS)
`define REFRESH_WINDOW_MS 64
`define REF_COUNT 8192
`define TREFI_NS 7810
`define TREFI_CYC (`TREFI_NS / `CLK_NS)
`define MASK_RD_LAT 2
`endif

// ### design/sdram_cmd_pkg.sv
/*
 Types shared by both ends: command codes, address and bank types.
 Assumes the cfg header sits beside it.
*/
`include "sdram_cmd_cfg.svh"
package sdram_cmd_pkg;
   // {ras_n, cas_n, we_n}
   typedef enum logic [2:0] {
      CMD_LMR = 3'h0, CMD_REF = 3'h1, CMD_PRE = 3'h2, CMD_ACT = 3'h3,
      CMD_WR = 3'h4, CMD_RD = 3'h5, CMD_BST = 3'h6, CMD_NOP = 3'h7
   } cmd_t;
   typedef logic [`ROW_W-1:0] addr_t;
   typedef logic [1:0] bank_t;
endpackage

// ### design/sdram_link_if.sv
/*
 Command and data pins between controller and SDRAM device.
 Assumes one shared clock; each end drives its own data bus with an enable.
*/
`timescale 1ns/1ps
interface sdram_link_if #(parameter int DW = 16) (input wire logic clk_sys);
   logic csN, rasN, casN, weN, clkGate;
   logic [1:0] bankSelect;
   logic [`ROW_W-1:0] addr;
   logic dataMask;
   logic [DW-1:0] dqCtl, dqDev;
   logic dqCtlOe, dqDevOe;
   modport device (input csN, rasN, casN, weN, clkGate, bankSelect, addr, dataMask,
      dqCtl, dqCtlOe, output dqDev, dqDevOe);
   modport host (output csN, rasN, casN, weN, clkGate, bankSelect, addr, dataMask,
      dqCtl, dqCtlOe, input dqDev, dqDevOe);
endinterface

// ### design/sdram_cmd_decoder.sv
/*
 Device end: command decode, bank state, burst engine over a small array.
 Assumes the controller keeps its timing obligations; one clock.
*/
`timescale 1ns/1ps
module sdram_cmd_decoder #(
   parameter int DW = 16,
   parameter int MEM_ROWS = 16
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   sdram_link_if.device link,
   output logic [`BANKS-1:0] bankOpen_r,
   output logic [`ROW_W-1:0] refreshRow_r,
   output logic selfRefresh_r
);
   import sdram_cmd_pkg::*;
   // the read mask path below is one register plus the output register
   initial if (DW < 1 || MEM_ROWS < 1 || `MASK_RD_LAT != 2) $error("bad parameters");

   logic [11:0] mode_r;
   logic [`ROW_W-1:0] openRow_r [`BANKS];
   logic [`TRP_CYC:0] preCnt_r [`BANKS];
   logic [DW-1:0] mem [MEM_ROWS*`BANKS*(1<<`COL_W)];
   logic burstOn_r, burstWr_r, autoPre_r;
   logic [1:0] burstBank_r;
   logic [`COL_W-1:0] startCol_r;
   logic [`COL_W:0] beat_r;
   logic maskPipe_r;
   logic rdVld_r;
   logic [DW-1:0] rdData_r;
   logic dqDev_oe_r;
   logic [DW-1:0] dqDev_r;
   cmd_t cmd;
   logic sel, fullPage, singleWr, lastBeat;
   logic [`COL_W:0] burstLen;
   logic [`COL_W-1:0] col;

   // ==========================================================
   // decode
   always_comb begin
      sel = !link.csN && link.clkGate;
      cmd = cmd_t'({link.rasN, link.casN, link.weN});
   end

   function automatic logic [`COL_W-1:0] beatCol(input logic [`COL_W-1:0] s,
         input logic [`COL_W:0] n, input logic [`COL_W:0] len, input logic il);
      logic [`COL_W-1:0] m;
      m = `COL_W'(len - 1);
      if (il) beatCol = (s & ~m) | ((s ^ n[`COL_W-1:0]) & m);
      else beatCol = (s & ~m) | ((s + n[`COL_W-1:0]) & m);
   endfunction

   always_comb begin
      fullPage = mode_r[2:0] == 3'h7;
      unique case (mode_r[2:0])
         3'h0: burstLen = (`COL_W+1)'(1);
         3'h1: burstLen = (`COL_W+1)'(2);
         3'h2: burstLen = (`COL_W+1)'(4);
         3'h3: burstLen = (`COL_W+1)'(8);
         default: burstLen = (`COL_W+1)'(1 << `COL_W);
      endcase
      singleWr = burstWr_r && mode_r[`MODE_WB_BIT];
      lastBeat = singleWr || (!fullPage && beat_r == burstLen - 1);
      col = beatCol(startCol_r, beat_r, burstLen,
         mode_r[`MODE_BT_BIT] && !fullPage);
   end

   // ==========================================================
   // mode register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) mode_r <= `MODE_RESET;
      else if (sel && cmd == CMD_LMR) mode_r <= link.addr[11:0];
   end

   // ==========================================================
   // bank state
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bankOpen_r <= '0;
         for (int b = 0; b < `BANKS; b++) begin
            openRow_r[b] <= '0;
            preCnt_r[b] <= '0;
         end
      end else begin
         for (int b = 0; b < `BANKS; b++)
            if (preCnt_r[b] != 0) preCnt_r[b] <= preCnt_r[b] - 1'b1;
         if (burstOn_r && lastBeat && autoPre_r) begin
            bankOpen_r[burstBank_r] <= 1'b0;
            preCnt_r[burstBank_r] <= (`TRP_CYC+1)'(`TRP_CYC);
         end
         if (sel) begin
            unique case (cmd)
               CMD_ACT: begin
                  if (preCnt_r[link.bankSelect] == 0) begin
                     bankOpen_r[link.bankSelect] <= 1'b1;
                     openRow_r[link.bankSelect] <= link.addr;
                  end
               end
               CMD_PRE: begin
                  for (int b = 0; b < `BANKS; b++)
                     if (link.addr[`PRE_FLAG_BIT] || link.bankSelect == b) begin
                        bankOpen_r[b] <= 1'b0;
                        preCnt_r[b] <= (`TRP_CYC+1)'(`TRP_CYC);
                     end
               end
               default: ;
            endcase
         end
      end
   end

   // ==========================================================
   // refresh counter and self refresh state
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         refreshRow_r <= '0;
         selfRefresh_r <= 1'b0;
      end else if (!link.csN && cmd == CMD_REF && !selfRefresh_r) begin
         refreshRow_r <= refreshRow_r + 1'b1;
         selfRefresh_r <= !link.clkGate;
      end else if (link.clkGate) begin
         selfRefresh_r <= 1'b0;
      end
   end

   // ==========================================================
   // burst engine
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         burstOn_r <= 1'b0;
         burstWr_r <= 1'b0;
         autoPre_r <= 1'b0;
         burstBank_r <= '0;
         startCol_r <= '0;
         beat_r <= '0;
      end else if (sel && (cmd == CMD_RD || cmd == CMD_WR)) begin
         burstOn_r <= 1'b1;
         burstWr_r <= cmd == CMD_WR;
         autoPre_r <= link.addr[`PRE_FLAG_BIT] && !fullPage;
         burstBank_r <= link.bankSelect;
         startCol_r <= link.addr[`COL_W-1:0];
         beat_r <= '0;
      end else if (sel && cmd == CMD_BST) begin
         burstOn_r <= 1'b0;
         autoPre_r <= 1'b0;
      end else if (burstOn_r) begin
         if (lastBeat) begin
            burstOn_r <= 1'b0;
            autoPre_r <= 1'b0;
         end
         beat_r <= beat_r + 1'b1;
      end
   end

   // shallow row folding keeps the array small; aliasing above MEM_ROWS
   function automatic int memIdx(input logic [1:0] b, input logic [`ROW_W-1:0] r,
         input logic [`COL_W-1:0] c);
      memIdx = ((int'(b) * MEM_ROWS + int'(r) % MEM_ROWS) << `COL_W) + int'(c);
   endfunction

   // ==========================================================
   // write path, mask with no latency
   always_ff @(posedge clk_sys) begin
      if (burstOn_r && burstWr_r && !link.dataMask)
         mem[memIdx(burstBank_r, openRow_r[burstBank_r], col)] <= link.dqCtl;
   end

   // ==========================================================
   // read path: latency pipe and mask pipe
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdVld_r <= 1'b0;
         maskPipe_r <= 1'b0;
         rdData_r <= '0;
         dqDev_oe_r <= 1'b0;
         dqDev_r <= '0;
      end else begin
         // mask register plus output register: valid two edges after the mask
         maskPipe_r <= link.dataMask;
         rdVld_r <= burstOn_r && !burstWr_r;
         rdData_r <= mem[memIdx(burstBank_r, openRow_r[burstBank_r], col)];
         // a write command forces high impedance at once to avoid contention
         if (mode_r[6:4] == 3'h3) begin
            dqDev_oe_r <= rdVld_r && !maskPipe_r && !(sel && cmd == CMD_WR);
            dqDev_r <= rdData_r;
         end else begin
            dqDev_oe_r <= burstOn_r && !burstWr_r && !maskPipe_r && !(sel && cmd == CMD_WR);
            dqDev_r <= mem[memIdx(burstBank_r, openRow_r[burstBank_r], col)];
         end
      end
   end
   assign link.dqDev = dqDev_r;
   assign link.dqDevOe = dqDev_oe_r;
endmodule

// ### design/sdram_cmd_host.sv
/*
 Controller end: registers one user command per request onto the pins,
 enforcing idle-only mode load and precharge waits, flagging periodic refresh need.
 Assumes the user sequences commands; this end blocks mode loads and refreshes with banks open and any command during a wait.
*/
`timescale 1ns/1ps
module sdram_cmd_host #(
   parameter int DW = 16,
   parameter int REFI_CYC = `TREFI_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   sdram_link_if.host link,
   input wire logic reqValid,
   input wire sdram_cmd_pkg::cmd_t reqCmd,
   input wire logic [1:0] reqBank,
   input wire logic [`ROW_W-1:0] reqAddr,
   input wire logic reqMask,
   input wire logic [DW-1:0] reqData,
   input wire logic reqDataOe,
   input wire logic reqSelfRefresh,
   output logic reqTaken_r,
   output logic refreshDue_r
);
   import sdram_cmd_pkg::*;
   initial if (REFI_CYC < 1) $error("bad REFI_CYC");

   logic [`BANKS-1:0] open_r;
   logic [3:0] wait_r;
   logic [15:0] refCnt_r;
   logic ok;
   logic csN_r, rasN_r, casN_r, weN_r, gate_r, mask_r, oe_r;
   logic [1:0] bank_r;
   logic [`ROW_W-1:0] addr_r;
   logic [DW-1:0] data_r;

   always_comb begin
      ok = wait_r == 0;
      unique case (reqCmd)
         CMD_LMR: ok = ok && open_r == 0 && !reqAddr[12];
         CMD_REF: ok = ok && open_r == 0;
         default: ;
      endcase
   end

   // ==========================================================
   // pin drive
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         {csN_r, rasN_r, casN_r, weN_r} <= 4'hF;
         gate_r <= 1'b1;
         bank_r <= '0;
         addr_r <= '0;
         mask_r <= 1'b0;
         data_r <= '0;
         oe_r <= 1'b0;
         reqTaken_r <= 1'b0;
      end else begin
         reqTaken_r <= reqValid && ok;
         csN_r <= !(reqValid && ok);
         {rasN_r, casN_r, weN_r} <= reqValid && ok ? reqCmd : CMD_NOP;
         // clock gate stays low for as long as self refresh is asked for
         gate_r <= !(reqSelfRefresh && (!gate_r || (reqValid && ok && reqCmd == CMD_REF)));
         bank_r <= reqBank;
         addr_r <= reqAddr;
         mask_r <= reqMask;
         data_r <= reqData;
         oe_r <= reqDataOe;
      end
   end

   // ==========================================================
   // bank tracking and waits
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         open_r <= '0;
         wait_r <= '0;
      end else if (reqValid && ok) begin
         wait_r <= '0;
         unique case (reqCmd)
            CMD_ACT: open_r[reqBank] <= 1'b1;
            CMD_PRE: begin
               for (int b = 0; b < `BANKS; b++)
                  if (reqAddr[`PRE_FLAG_BIT] || reqBank == b) open_r[b] <= 1'b0;
               wait_r <= 4'(`TRP_CYC);
            end
            CMD_RD, CMD_WR:
               if (reqAddr[`PRE_FLAG_BIT]) begin
                  open_r[reqBank] <= 1'b0;
                  wait_r <= 4'(`TRP_CYC + 8);
               end
            CMD_LMR: wait_r <= 4'(`MODE_LOAD_DELAY_CYC);
            default: ;
         endcase
      end else if (wait_r != 0) begin
         wait_r <= wait_r - 1'b1;
      end
   end

   // ==========================================================
   // refresh interval watch, one refresh per interval
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         refCnt_r <= '0;
         refreshDue_r <= 1'b0;
      end else if (reqValid && ok && reqCmd == CMD_REF) begin
         refCnt_r <= '0;
         refreshDue_r <= 1'b0;
      end else if (refCnt_r >= 16'(REFI_CYC - 1)) begin
         refreshDue_r <= 1'b1;
      end else begin
         refCnt_r <= refCnt_r + 1'b1;
      end
   end

   assign link.csN = csN_r;
   assign link.rasN = rasN_r;
   assign link.casN = casN_r;
   assign link.weN = weN_r;
   assign link.clkGate = gate_r;
   assign link.bankSelect = bank_r;
   assign link.addr = addr_r;
   assign link.dataMask = mask_r;
   assign link.dqCtl = data_r;
   assign link.dqCtlOe = oe_r;
endmodule

// ### dv/sdram_cmd_decoder_sva.sv
/*
 Checker for the link between controller end and device end.
 Assumes plain link signals plus the device status outputs, one clock.
*/
`timescale 1ns/1ps
module sdram_cmd_decoder_sva (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic csN,
   input wire logic rasN,
   input wire logic casN,
   input wire logic weN,
   input wire logic clkGate,
   input wire logic [1:0] bankSelect,
   input wire logic [`ROW_W-1:0] addr,
   input wire logic dataMask,
   input wire logic dqCtlOe,
   input wire logic dqDevOe,
   input wire logic [`BANKS-1:0] bankOpen_r,
   input wire logic selfRefresh_r
);
   import sdram_cmd_pkg::*;
   logic [2:0] cmd;
   logic sel;
   assign cmd = {rasN, casN, weN};
   assign sel = !csN && clkGate;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // sequences
   sequence s_rdOpen;
      sel && cmd == CMD_RD && !dataMask;
   endsequence
   sequence s_quiet;
      (csN || cmd == CMD_NOP) [*8];
   endsequence
   // ==========================================
   // properties
   property p_rdLatency;
      s_rdOpen |-> ##2 dqDevOe;
   endproperty
   property p_rdMask;
      dataMask |-> ##2 !dqDevOe;
   endproperty
   property p_lmrAddr;
      sel && cmd == CMD_LMR |-> !addr[12];
   endproperty
   property p_lmrGap;
      sel && cmd == CMD_LMR |=> (csN || cmd == CMD_NOP);
   endproperty
   property p_clkGate;
      !csN && cmd != CMD_REF |-> clkGate;
   endproperty
   property p_actOpen;
      sel && cmd == CMD_ACT |=> bankOpen_r[$past(bankSelect)];
   endproperty
   property p_preOne;
      sel && cmd == CMD_PRE && !addr[10] |=> !bankOpen_r[$past(bankSelect)];
   endproperty
   property p_preAll;
      sel && cmd == CMD_PRE && addr[10] |=> bankOpen_r == 4'h0;
   endproperty
   property p_selfRef;
      !csN && cmd == CMD_REF && !clkGate |=> selfRefresh_r;
   endproperty
   // long idle stretch lets any burst of up to eight beats finish first
   property p_quiet;
      s_quiet ##1 (csN || cmd == CMD_NOP) |=> $stable(bankOpen_r);
   endproperty
   property p_noClash;
      !(dqCtlOe && dqDevOe);
   endproperty
   a_rdLatency: assert property (p_rdLatency) else $error("read data late");
   a_rdMask: assert property (p_rdMask) else $error("masked read driven");
   a_lmrAddr: assert property (p_lmrAddr) else $error("mode load top bit set");
   a_lmrGap: assert property (p_lmrGap) else $error("command in mode delay");
   a_clkGate: assert property (p_clkGate) else $error("clock gate low");
   a_actOpen: assert property (p_actOpen) else $error("row not opened");
   a_preOne: assert property (p_preOne) else $error("bank not closed");
   a_preAll: assert property (p_preAll) else $error("banks not all closed");
   a_selfRef: assert property (p_selfRef) else $error("self refresh missed");
   a_quiet: assert property (p_quiet) else $error("idle changed banks");
   a_noClash: assert property (p_noClash) else $error("data bus contention");
endmodule

// ### dv/sdram_cmd_decoder_tb_top.sv
/*
 Testbench: controller end and device end joined by the link interface.
 Assumes the design package and config header are compiled first.
*/
`timescale 1ns/1ps
module sdram_cmd_decoder_tb_top;
   import sdram_cmd_pkg::*;
   logic clk_sys, rst_n, reqValid, reqMask, reqDataOe, reqSelfRefresh;
   logic reqTaken_r, refreshDue_r, selfRefresh_r, ok;
   cmd_t reqCmd;
   logic [1:0] reqBank;
   logic [`ROW_W-1:0] reqAddr, refreshRow_r, row0;
   logic [15:0] reqData, dWb;
   logic [`BANKS-1:0] bankOpen_r;
   logic [15:0] expQ[$];
   logic [15:0] wd[4], fd[4];
   int fails, tests_run, cyc, seed;

   initial begin
      clk_sys = 0;
      forever #20 clk_sys = ~clk_sys;
   end

   sdram_link_if #(.DW(16)) link (.clk_sys(clk_sys));
   sdram_cmd_host #(.DW(16), .REFI_CYC(20)) u_sdram_cmd_host (.clk_sys(clk_sys),
      .rst_n(rst_n), .link(link), .reqValid(reqValid), .reqCmd(reqCmd), .reqBank(reqBank),
      .reqAddr(reqAddr), .reqMask(reqMask), .reqData(reqData), .reqDataOe(reqDataOe),
      .reqSelfRefresh(reqSelfRefresh), .reqTaken_r(reqTaken_r), .refreshDue_r(refreshDue_r));
   sdram_cmd_decoder #(.DW(16)) u_sdram_cmd_decoder (.clk_sys(clk_sys), .rst_n(rst_n),
      .link(link), .bankOpen_r(bankOpen_r), .refreshRow_r(refreshRow_r),
      .selfRefresh_r(selfRefresh_r));
   sdram_cmd_decoder_sva u_sdram_cmd_decoder_sva (.clk_sys(clk_sys), .rst_n(rst_n),
      .csN(link.csN), .rasN(link.rasN), .casN(link.casN), .weN(link.weN),
      .clkGate(link.clkGate), .bankSelect(link.bankSelect), .addr(link.addr),
      .dataMask(link.dataMask), .dqCtlOe(link.dqCtlOe), .dqDevOe(link.dqDevOe),
      .bankOpen_r(bankOpen_r), .selfRefresh_r(selfRefresh_r));

   // ==========================================
   // checking and closing
   task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
      tests_run++;
      if (seen !== expv) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask

   task automatic print_verdict;
      $display("checks=%0d mismatches=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // read beats are matched against the oldest note
   always @(posedge clk_sys) begin
      if (rst_n && link.dqDevOe === 1'b1) begin
         if (expQ.size() == 0) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=none", $time, link.dqDev);
         end else begin
            chk(link.dqDev, expQ.pop_front());
         end
      end
   end

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         print_verdict();
      end
   end

   // ==========================================
   // drivers, all called just after an edge
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic issue(input cmd_t c, input logic [1:0] b, input logic [12:0] a,
         input logic m, output logic taken);
      int n;
      taken = 0;
      n = 0;
      reqCmd = c;
      reqBank = b;
      reqAddr = a;
      reqMask = m;
      reqValid = 1;
      // refused requests give up after a bounded wait
      while (!taken && n < 20) begin
         wait_cyc(1);
         taken = (reqTaken_r === 1'b1);
         n++;
      end
      reqValid = 0;
   endtask

   task automatic wdata(input logic [15:0] d, input logic m, input logic last);
      reqData = d;
      reqDataOe = 1;
      reqMask = m;
      wait_cyc(1);
      if (last) begin
         reqDataOe = 0;
         reqMask = 0;
      end
   endtask

   // ==========================================
   // main sequence
   initial begin
      seed = 32'hc7103c69;
      rst_n = 0;
      reqValid = 0;
      reqCmd = CMD_NOP;
      reqBank = 0;
      reqAddr = 0;
      reqMask = 0;
      reqData = 0;
      reqDataOe = 0;
      reqSelfRefresh = 0;
      dWb = $random(seed);
      repeat (16) @(posedge clk_sys);
      #1 rst_n = 1;
      chk(16'(bankOpen_r), 16'h0000);
      for (int b = 0; b < 4; b++) begin
         wd[b] = $random(seed);
         fd[b] = $random(seed);
         issue(CMD_ACT, b[1:0], 13'(b + 1), 0, ok);
      end
      wait_cyc(2);
      chk(16'(bankOpen_r), 16'h000F);
      for (int b = 0; b < 4; b++) begin
         issue(CMD_WR, b[1:0], 13'h0004, 0, ok);
         wdata(wd[b], 0, 1);
         issue(CMD_WR, b[1:0], 13'h0005, 0, ok);
         wdata(fd[b], 0, 1);
         issue(CMD_WR, b[1:0], 13'h0005, 0, ok);
         wdata(~fd[b], 1, 1);
      end
      for (int b = 0; b < 4; b++) begin
         issue(CMD_RD, b[1:0], 13'h0004, 0, ok);
         expQ.push_back(wd[b]);
         issue(CMD_RD, b[1:0], 13'h0005, 0, ok);
         expQ.push_back(fd[b]);
         issue(CMD_RD, b[1:0], 13'h0004, 1, ok);
      end
      issue(CMD_LMR, 2'h0, 13'h0221, 0, ok);
      chk(16'(ok), 16'h0000);
      issue(CMD_PRE, 2'h1, 13'h0000, 0, ok);
      wait_cyc(2);
      chk(16'(bankOpen_r), 16'h000D);
      issue(CMD_PRE, 2'h2, 13'h0400, 0, ok);
      wait_cyc(2);
      chk(16'(bankOpen_r), 16'h0000);
      issue(CMD_LMR, 2'h0, 13'h1221, 0, ok);
      chk(16'(ok), 16'h0000);
      // writes single, reads burst of two
      issue(CMD_LMR, 2'h0, 13'h0221, 0, ok);
      chk(16'(ok), 16'h0001);
      issue(CMD_ACT, 2'h0, 13'h0001, 0, ok);
      issue(CMD_WR, 2'h0, 13'h0004, 0, ok);
      wdata(dWb, 0, 0);
      wdata(~dWb, 0, 1);
      issue(CMD_RD, 2'h0, 13'h0404, 0, ok);
      expQ.push_back(dWb);
      expQ.push_back(fd[0]);
      wait_cyc(12);
      chk(16'(bankOpen_r[0]), 16'h0000);
      chk(16'(expQ.size()), 16'h0000);
      row0 = refreshRow_r;
      issue(CMD_REF, 2'h0, 13'h0000, 0, ok);
      wait_cyc(2);
      chk(16'(refreshRow_r !== row0), 16'h0001);
      wait_cyc(22);
      chk(16'(refreshDue_r), 16'h0001);
      issue(CMD_REF, 2'h3, 13'h1FFF, 0, ok);
      wait_cyc(1);
      chk(16'(refreshDue_r), 16'h0000);
      reqSelfRefresh = 1;
      issue(CMD_REF, 2'h0, 13'h0000, 0, ok);
      wait_cyc(2);
      chk(16'(selfRefresh_r), 16'h0001);
      print_verdict();
   end
endmodule
